// File: incr_or_shift_jump_absolute_op_exec.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - increment-and-skip with a zero result replaces the next instruction with a no-op, two cycles.
// - increment-and-skip with a non-zero result lets the next instruction run normally.
// - destination bit 0 writes the working register, 1 writes the addressed file register.
// - plain increment adds one to the file register, stores to the destination, updates zero.
// - the jump loads its 11-bit operand into program counter bits 10 to 0.
// - the jump fills program counter bits 14 to 11 from page latch bits 6 to 3.
// - the jump always takes two instruction cycles.
// - or-literal ors the working register with an 8-bit literal into the working register, updating zero.
// - or-with-file ors the working register with the file register into the destination, updating zero.
// - left shift moves operand bit 7 to carry and bits 6 to 0 into result bits 7 to 1.
// - left shift inserts zero at bit 0, updates carry and zero, writes the destination.
module incr_or_shift_jump_absolute_op_exec
  import incr_or_shift_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  // clock and reset
  input  wire logic                                    clk,
  input  wire logic                                    rst,
  // instruction from fetch
  input  wire logic                                    cmd_valid,
  input  wire incr_or_shift_pkg::cmd_t                 cmd,
  output logic                                         cmd_ready_r,
  // page latch from the core
  input  wire logic [incr_or_shift_pkg::LATCH_W-1:0]   program_page_latch,
  // file register preload, honoured only while idle
  input  wire incr_or_shift_pkg::file_wr_t             preload,
  // architectural state
  output logic [incr_or_shift_pkg::DATA_W-1:0]         w_r,
  output logic                                         zero_r,
  output logic                                         carry_r,
  output logic [incr_or_shift_pkg::PC_W-1:0]           pc_r,
  // retire and skip indications
  output logic                                         done_r,
  output logic                                         skip_r
);
  import incr_or_shift_pkg::*;

  if (FILE_DEPTH > (1 << FADDR_W) || FILE_DEPTH < 1)
  begin : g_bad_depth
    $error("incr_or_shift_jump_absolute_op_exec: file depth exceeds 7-bit address space");
  end

  // ----------------------------------------
  // state and latched instruction
  // ----------------------------------------
  state_t              state_r;
  state_t              state_nxt;
  cmd_t                cur_r;
  logic [DATA_W-1:0]   fdata;
  logic [DATA_W-1:0]   result;
  logic                res_carry;
  logic                uses_file;
  logic                to_file;
  logic                two_cycle;
  logic                mem_we;
  logic [FADDR_W-1:0]  mem_waddr;
  logic [DATA_W-1:0]   mem_wdata;

  assign uses_file = (cmd.op != jump_absolute_op) && (cmd.op != or_literal_working_op);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur_r <= '0;
    end
    else if (state_r == st_idle && cmd_valid)
    begin
      cur_r <= cmd;
    end
  end

  // ----------------------------------------
  // file register storage
  // ----------------------------------------
  always_comb
  begin
    mem_we    = preload.en && (state_r == st_idle);
    mem_waddr = preload.addr;
    mem_wdata = preload.data;
    if (state_r == st_exec && to_file)
    begin
      mem_we    = 1'b1;
      mem_waddr = cur_r.faddr;
      mem_wdata = result;
    end
  end

  file_reg_mem #(
    .DEPTH   (FILE_DEPTH),
    .AW      (FADDR_W),
    .DW      (DATA_W)
  ) u_mem (
    .clk     (clk),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (cur_r.faddr),
    .rd_data (fdata)
  );

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  always_comb
  begin
    result    = fdata;
    res_carry = carry_r;
    case (cur_r.op)
      increment_skip_zero_op,
      increment_file_op:
      begin
        result = DATA_W'(fdata + 8'h01);
      end
      or_literal_working_op:
      begin
        result = w_r | cur_r.lit[LIT_BYTE_HI:0];
      end
      or_working_file_op:
      begin
        result = w_r | fdata;
      end
      shift_left_logical_op:
      begin
        result    = {fdata[DATA_W-2:0], 1'b0};
        res_carry = fdata[DATA_W-1];
      end
      default:
      begin
        result = fdata;
      end
    endcase
  end

  // literal-or always targets the working register; jump writes no data
  assign to_file = (cur_r.dest == DEST_FILE)
                   && (cur_r.op != or_literal_working_op)
                   && (cur_r.op != jump_absolute_op);

  // jump always, skip only on a zero result
  assign two_cycle = (cur_r.op == jump_absolute_op)
                     || (cur_r.op == increment_skip_zero_op
                         && result == 8'h00);

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      st_idle:
      begin
        if (cmd_valid)
        begin
          state_nxt = uses_file ? st_fetch : st_exec;
        end
      end
      st_fetch:
      begin
        state_nxt = st_exec;
      end
      st_exec:
      begin
        state_nxt = two_cycle ? st_extra : st_idle;
      end
      st_extra:
      begin
        state_nxt = st_idle;
      end
      default:
      begin
        state_nxt = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= st_idle;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd_ready_r <= 1'b1;
    end
    else
    begin
      cmd_ready_r <= (state_nxt == st_idle);
    end
  end

  // ----------------------------------------
  // working register and flags
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      w_r <= W_RESET;
    end
    else if (state_r == st_exec && cur_r.op != jump_absolute_op && !to_file)
    begin
      w_r <= result;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      zero_r <= FLAG_RESET;
    end
    else if (state_r == st_exec
             && cur_r.op != jump_absolute_op
             && cur_r.op != increment_skip_zero_op)
    begin
      zero_r <= (result == 8'h00);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      carry_r <= FLAG_RESET;
    end
    else if (state_r == st_exec && cur_r.op == shift_left_logical_op)
    begin
      carry_r <= res_carry;
    end
  end

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  // the skipped slot still advances the counter, as the replaced word is consumed
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pc_r <= PC_RESET;
    end
    else if (state_r == st_exec && cur_r.op == jump_absolute_op)
    begin
      pc_r[PC_LOW_HI:0]          <= cur_r.lit;
      pc_r[PC_PAGE_HI:PC_PAGE_LO] <= program_page_latch[LATCH_PG_HI:LATCH_PG_LO];
    end
    else if (state_r == st_exec
             || (state_r == st_extra && cur_r.op == increment_skip_zero_op))
    begin
      pc_r <= PC_W'(pc_r + 15'h0001);
    end
  end

  // ----------------------------------------
  // retire and skip pulses
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      done_r <= 1'b0;
      skip_r <= 1'b0;
    end
    else
    begin
      done_r <= (state_r == st_exec && !two_cycle) || (state_r == st_extra);
      skip_r <= (state_r == st_extra && cur_r.op == increment_skip_zero_op);
    end
  end

endmodule

`default_nettype wire

// File: incr_or_shift_pkg.sv
package incr_or_shift_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;
  localparam int LIT_W   = 11;
  localparam int PC_W    = 15;
  localparam int LATCH_W = 7;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PC_LOW_HI    = 10;
  localparam int PC_PAGE_LO   = 11;
  localparam int PC_PAGE_HI   = 14;
  localparam int LATCH_PG_LO  = 3;
  localparam int LATCH_PG_HI  = 6;
  localparam int LIT_BYTE_HI  = 7;

  // ----------------------------------------
  // reset values and cycle counts
  // ----------------------------------------
  localparam logic [DATA_W-1:0] W_RESET     = 8'h00;
  localparam logic [PC_W-1:0]   PC_RESET    = 15'h0000;
  localparam logic              FLAG_RESET  = 1'b0;
  localparam logic              DEST_W_REG  = 1'b0;
  localparam logic              DEST_FILE   = 1'b1;
  localparam int                JUMP_CYCLES = 2;
  localparam int                SKIP_CYCLES = 2;

  // ----------------------------------------
  // operations and states
  // ----------------------------------------
  typedef enum logic [2:0] {
    increment_skip_zero_op = 3'h0,
    increment_file_op      = 3'h1,
    jump_absolute_op       = 3'h2,
    or_literal_working_op  = 3'h3,
    or_working_file_op     = 3'h4,
    shift_left_logical_op  = 3'h5
  } op_t;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_fetch = 2'b01,
    st_exec  = 2'b11,
    st_extra = 2'b10
  } state_t;

  typedef struct packed {
    op_t                op;
    logic [FADDR_W-1:0] faddr;
    logic               dest;
    logic [LIT_W-1:0]   lit;
  } cmd_t;

  typedef struct packed {
    logic               en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } file_wr_t;

endpackage

// File: file_reg_mem.sv
`timescale 1ns/1ps
`default_nettype none

module file_reg_mem #(
  parameter int DEPTH  = 128,
  parameter int AW     = 7,
  parameter int DW     = 8
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // read port, data one cycle after address
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW) || DEPTH < 1)
  begin : g_bad_depth
    $error("file_reg_mem: depth does not fit address width");
  end

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // no reset on the read register: contents are undefined until written
  always_ff @(posedge clk)
  begin
    rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// File: incr_or_shift_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// port checks
// ----------------
module incr_or_shift_checker
  import incr_or_shift_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          cmd_valid,
  input wire incr_or_shift_pkg::cmd_t       cmd,
  input wire logic                          cmd_ready_r,
  input wire logic [incr_or_shift_pkg::LATCH_W-1:0] program_page_latch,
  input wire incr_or_shift_pkg::file_wr_t   preload,
  input wire logic [incr_or_shift_pkg::DATA_W-1:0]  w_r,
  input wire logic                          zero_r,
  input wire logic                          carry_r,
  input wire logic [incr_or_shift_pkg::PC_W-1:0]    pc_r,
  input wire logic                          done_r,
  input wire logic                          skip_r
);
  logic tk;
  assign tk = cmd_valid && cmd_ready_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // w_r is written at the edge that ends exec, so it is seen one edge later
  property p_orl_w;
    tk && cmd.op == or_literal_working_op
      |=> ##1 w_r == ($past(w_r, 2) | $past(cmd.lit[7:0], 2));
  endproperty
  a_orl_w: assert property (p_orl_w) else $error("or literal result wrong");
  property p_orl_z;
    tk && cmd.op == or_literal_working_op |=> ##1 zero_r == (w_r == 8'h00);
  endproperty
  a_orl_z: assert property (p_orl_z) else $error("or literal zero wrong");
  property p_jmp_pc;
    tk && cmd.op == jump_absolute_op
      |=> ##1 pc_r == {$past(program_page_latch[6:3]), $past(cmd.lit, 2)};
  endproperty
  a_jmp_pc: assert property (p_jmp_pc) else $error("jump target wrong");
  property p_jmp_len;
    tk && cmd.op == jump_absolute_op |=> !done_r ##1 !done_r ##1 done_r;
  endproperty
  a_jmp_len: assert property (p_jmp_len) else $error("jump length wrong");
  property p_skp_len;
    tk && cmd.op == increment_skip_zero_op
      |=> !done_r ##1 !done_r
          ##1 ((done_r && !skip_r) or (!done_r ##1 (done_r && skip_r)));
  endproperty
  a_skp_len: assert property (p_skp_len) else $error("skip timing wrong");
  property p_skp_pc;
    skip_r |-> done_r && pc_r == $past(pc_r, 2) + 15'h0002;
  endproperty
  a_skp_pc: assert property (p_skp_pc) else $error("skip pc wrong");
  // skip-increment and jump must not disturb zero
  property p_z_hold;
    tk && (cmd.op == increment_skip_zero_op || cmd.op == jump_absolute_op)
      |=> $stable(zero_r) [*3];
  endproperty
  a_z_hold: assert property (p_z_hold) else $error("zero changed");
  property p_c_hold;
    tk && cmd.op != shift_left_logical_op |=> $stable(carry_r) [*3];
  endproperty
  a_c_hold: assert property (p_c_hold) else $error("carry changed");
  c_skip: cover property (skip_r);
  c_jump: cover property (tk && cmd.op == jump_absolute_op);
  c_carry: cover property (done_r && carry_r);
endmodule
bind incr_or_shift_jump_absolute_op_exec incr_or_shift_checker u_incr_or_shift_checker (.clk, .rst,
  .cmd_valid, .cmd, .cmd_ready_r, .program_page_latch, .preload, .w_r, .zero_r, .carry_r,
  .pc_r, .done_r, .skip_r);
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module tb;
  import incr_or_shift_pkg::*;
  // ----------------
  // stimulus and model
  // ----------------
  logic        clk = 0, rst = 1, cmd_valid = 0, rdy, z, c, done, skip, ez = 0, ec = 0;
  cmd_t        cmd = '0;
  file_wr_t    preload = '0;
  logic [6:0]  latch = '0;
  logic [7:0]  w, ew = '0;
  logic [7:0]  mem [128];
  logic [14:0] pc, epc = '0;
  logic [31:0] seed = 32'h2676;
  int          error_cnt = 0, n_tests = 0;
  always #4 clk = ~clk;
  incr_or_shift_jump_absolute_op_exec u_incr_or_shift_jump_absolute_op_exec (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_r(rdy), .program_page_latch(latch),
    .preload(preload), .w_r(w), .zero_r(z), .carry_r(c), .pc_r(pc), .done_r(done),
    .skip_r(skip));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // model updated before the command goes out; latch held until done
  task automatic run(input op_t op, input logic [6:0] fa, input logic d,
                     input logic [10:0] k);
    int n;
    int lat;
    logic [7:0] res;
    logic sk;
    sk = 0;
    lat = 3;
    res = mem[fa] + 8'h01;
    case (op)
      increment_skip_zero_op: sk = (res == 8'h00);
      or_working_file_op:     res = ew | mem[fa];
      shift_left_logical_op:
      begin
        ec = mem[fa][7];
        res = {mem[fa][6:0], 1'b0};
      end
      or_literal_working_op:
      begin
        res = ew | k[7:0];
        lat = 2;
      end
      default: ;
    endcase
    if (op != increment_skip_zero_op && op != jump_absolute_op)
      ez = (res == 8'h00);
    if (op == or_literal_working_op)
      ew = res;
    else if (op != jump_absolute_op && d)
      mem[fa] = res;
    else if (op != jump_absolute_op)
      ew = res;
    epc = (op == jump_absolute_op) ? {latch[6:3], k} : epc + 15'h0001 + 15'(sk);
    lat += int'(sk);
    cmd_valid = 1;
    cmd = '{op, fa, d, k};
    n = 0;
    while (rdy !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 20)
    begin
      error_cnt++;
      print_verdict();
    end
    @(posedge clk);
    #1 cmd_valid = 0;
    `CHK("busy", 1'b0, rdy)
    n = 1;
    while (done !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 20)
    begin
      error_cnt++;
      print_verdict();
    end
    `CHK("cycles", lat, n)
    `CHK("ready", 1'b1, rdy)
    `CHK("skip", sk, skip)
    `CHK("w", ew, w)
    `CHK("zero", ez, z)
    `CHK("carry", ec, c)
    `CHK("pc", epc, pc)
  endtask
  // ----------------
  // sequence
  // ----------------
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst = 0;
    for (int i = 0; i < 128; i++)
    begin
      seed = lfsr(seed);
      mem[i] = (i == 5 || i == 7) ? 8'hff : (i == 6) ? 8'h80 : seed[7:0];
      preload = '{1'b1, 7'(i), mem[i]};
      @(posedge clk);
      #1;
    end
    preload = '0;
    run(or_literal_working_op, 7'h00, 1'b0, 11'h000);
    run(increment_skip_zero_op, 7'h05, 1'b1, 11'h000);
    run(increment_skip_zero_op, 7'h05, 1'b1, 11'h000);
    run(increment_file_op, 7'h07, 1'b0, 11'h000);
    run(shift_left_logical_op, 7'h06, 1'b0, 11'h000);
    run(or_working_file_op, 7'h7f, 1'b1, 11'h000);
    latch = 7'h7f;
    run(jump_absolute_op, 7'h00, 1'b0, 11'h7ff);
    for (int i = 0; i < 300; i++)
    begin
      seed = lfsr(seed);
      latch = seed[6:0];
      run(op_t'(seed[10:8] % 3'd6), seed[17:11], seed[18], seed[29:19]);
    end
    print_verdict();
  end
  initial
  begin
    #200000;
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
